// ---- design/adc_control_register.sv ----
// The APB register port was decided locally.
`include "adc_ctrl_cfg.svh"

module adc_control_register
  import adc_ctrl_pkg::*;
#(
  parameter int TAD_CYCLES = `TAD_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        cmp_above,
  output logic      [9:0]  dac_code,
  output logic      [3:0]  analog_select,
  output logic             sample_enable,
  output logic             reference_select,
  output logic             converter_power_on,
  output logic             conversion_done_flag
);

  adc_state_t st_reg;
  adc_state_t st_next;

  logic       tad_tick;
  logic       timer_restart;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic [7:0] ctrl_read;
  logic       setup_rd;
  logic       ctrl_wr;
  logic       mapped;

  // ****************************************
  // Submodules
  // ****************************************
  tad_timer #(
    .TAD_CYCLES (TAD_CYCLES)
  ) u_tad_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .restart (timer_restart),
    .tick    (tad_tick)
  );

  result_format u_result_format (
    .right_just (st_reg.fmt),
    .result     (st_reg.result),
    .res_high   (result_high),
    .res_low    (result_low)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign mapped   = paddr == `CTRL_ADDR || paddr == `RES_HIGH_ADDR
                    || paddr == `RES_LOW_ADDR;
  assign setup_rd = psel && !penable;
  assign ctrl_wr  = psel && penable && pwrite && paddr == `CTRL_ADDR;

  // Bits 5:4 always zero
  assign ctrl_read = {st_reg.fmt, st_reg.refsel, 2'b00, st_reg.chs,
                      st_reg.go, st_reg.power};  // see R3

  assign timer_restart = st_reg.state == ST_IDLE
                         || (ctrl_wr && !pwdata[`GO_BIT]
                             && st_reg.state == ST_CONVERT);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next        = st_reg;
    st_next.done   = 1'b0;
    st_next.cmp_s1 = cmp_above;
    st_next.cmp_s2 = st_reg.cmp_s1;

    if (setup_rd) begin
      st_next.slverr = !mapped;
      st_next.prdata = 32'h0000_0000;
      if (paddr == `CTRL_ADDR) begin
        st_next.prdata = {24'h00_0000, ctrl_read};
      end else if (paddr == `RES_HIGH_ADDR) begin
        st_next.prdata = {24'h00_0000, result_high};  // see R2
      end else if (paddr == `RES_LOW_ADDR) begin
        st_next.prdata = {24'h00_0000, result_low};   // see R2
      end
    end

    case (st_reg.state)
      ST_IDLE: begin
        if (st_reg.go && st_reg.power) begin
          st_next.state = ST_CONVERT;
          st_next.step  = 4'h0;
          st_next.code  = 10'h000;
        end else if (st_reg.go) begin
          st_next.go = 1'b0;
        end
      end
      ST_CONVERT: begin
        if (!st_reg.power) begin
          st_next.state = ST_IDLE;
          st_next.go    = 1'b0;
        end else if (tad_tick) begin
          if (st_reg.step == 4'h0) begin
            st_next.code = 10'h200;
          end else begin
            st_next.code[4'd10 - st_reg.step] = st_reg.cmp_s2;
            if (st_reg.step != `CONV_TADS) begin
              st_next.code[4'd9 - st_reg.step] = 1'b1;
            end
          end
          st_next.step = st_reg.step + 4'h1;
          if (st_reg.step == `CONV_TADS) begin
            st_next.result = {st_next.code};
            st_next.go     = 1'b0;  // see R7
            st_next.done   = 1'b1;  // see R7
            st_next.state  = ST_IDLE;
          end
        end
      end
      ST_HOLDOFF: begin
        if (tad_tick) begin
          st_next.hold_cnt = st_reg.hold_cnt + 2'h1;
          if (st_reg.hold_cnt + 2'h1 == `HOLDOFF_TADS) begin
            st_next.state = ST_IDLE;  // see R8
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    if (ctrl_wr) begin
      st_next.fmt    = pwdata[`FMT_BIT];                        // see R1
      st_next.refsel = pwdata[`REF_BIT];                        // see R6
      st_next.chs    = pwdata[`CHS_HI_BIT:`CHS_LO_BIT];         // see R4
      st_next.power  = pwdata[`PWR_BIT];                        // see R5
      if (pwdata[`GO_BIT]) begin
        // Software set wins over completion clear
        st_next.go = 1'b1;                                      // see R7
        if (st_reg.state == ST_CONVERT && st_next.state == ST_IDLE
            && pwdata[`PWR_BIT]) begin
          st_next.state = ST_IDLE;
        end
      end else begin
        st_next.go = 1'b0;
        if (st_reg.state == ST_CONVERT && !pwdata[`PWR_BIT]) begin
          // Power off drops the conversion, no holdoff
          st_next.state = ST_IDLE;                              // see R5
        end else if (st_reg.state == ST_CONVERT && st_next.done == 1'b0) begin
          // Abort: result untouched, wait before acquiring again
          st_next.state    = ST_HOLDOFF;                        // see R8
          st_next.hold_cnt = 2'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;  // see R9
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready               = 1'b1;
  assign prdata               = st_reg.prdata;
  assign pslverr              = st_reg.slverr && psel && penable;
  assign dac_code             = st_reg.code;
  assign analog_select        = 4'h1 << st_reg.chs;              // see R4
  assign sample_enable        = st_reg.power && st_reg.state == ST_IDLE
                                && !st_reg.go;                   // see R5
  assign reference_select     = st_reg.refsel;                   // see R6
  assign converter_power_on   = st_reg.power;                    // see R5
  assign conversion_done_flag = st_reg.done;

  // ****************************************
  // Assertions
  // ****************************************
  a_reserved_bits_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (psel && penable && !pwrite && paddr == `CTRL_ADDR) |-> prdata[5:4] == 2'b00) // see R3
    else $error("reserved control bits read nonzero");

  a_right_justify: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_reg.fmt |-> result_low == st_reg.result[7:0]
                   && result_high == {6'h00, st_reg.result[9:8]}) // see R1
    else $error("right justified layout wrong");

  a_left_justify: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_wr && !pwdata[`FMT_BIT]) |=> result_high == st_reg.result[9:2]
                                       && result_low[5:0] == 6'h00) // see R2
    else $error("left justified layout wrong");

  a_channel_map: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_wr && pwdata[3:2] == 2'b10) |=> analog_select == 4'b0100) // see R4
    else $error("channel select decode wrong");

  a_power_off_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_wr && !pwdata[`PWR_BIT]) |=> !sample_enable ##1 st_reg.state != ST_CONVERT) // see R5
    else $error("converter active while off");

  a_ref_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrl_wr |=> reference_select == $past(pwdata[`REF_BIT])) // see R6
    else $error("reference select not updated");

  a_done_clears_go: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(conversion_done_flag) |-> !st_reg.go || $past(ctrl_wr)) // see R7
    else $error("start bit not cleared at completion");

  a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_reg.state == ST_HOLDOFF) |-> $stable(st_reg.result) && !sample_enable) // see R8
    else $error("abort changed result or acquired early");

  a_holdoff_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_reg.state == ST_HOLDOFF && tad_tick && st_reg.hold_cnt == 2'h1)
      |=> st_reg.state == ST_IDLE) // see R8
    else $error("holdoff length wrong");

  a_reset_clear: assert property (@(posedge ref_clk)
    !nrst |-> ctrl_read == `CTRL_RESET && st_reg.state == ST_IDLE) // see R9
    else $error("control not cleared by reset");

endmodule // adc_control_register

// ---- design/adc_ctrl_cfg.svh ----
// What this block does
// R1 - Control bit 7 set right-justifies the 10-bit result, clear left-justifies it.
// R2 - Only the format bit decides how the result registers present the value.
// R3 - Control bits 5 and 4 are unimplemented, read zero, ignore writes.
// R4 - Channel field bits 3:2 connects input 0..3 to the sample and hold.
// R5 - Power bit 0 set keeps the converter running, clear shuts it off.
// R6 - Reference bit set picks the external reference pin, clear picks supply.
// R7 - Software sets start/busy; completion clears it unless a write sets it in that cycle, and pulses the done flag.
// R8 - Clearing start/busy mid-conversion aborts, keeps result, waits 2 periods; a write that also clears power skips the wait.
// R9 - Every implemented control bit resets to zero; converter off, idle.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define CTRL_IDX      10'h01F
`define RES_HIGH_IDX  10'h01E
`define RES_LOW_IDX   10'h01D
`define CTRL_ADDR     {`CTRL_IDX, 2'b00}
`define RES_HIGH_ADDR {`RES_HIGH_IDX, 2'b00}
`define RES_LOW_ADDR  {`RES_LOW_IDX, 2'b00}

// ****************************************
// Control fields
// ****************************************
`define FMT_BIT    7
`define REF_BIT    6
`define CHS_HI_BIT 3
`define CHS_LO_BIT 2
`define GO_BIT     1
`define PWR_BIT    0
`define CTRL_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_NS       4
`define TAD_NS       1600
`define TAD_CYC      ((`TAD_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLDOFF_TADS 2'h2
`define CONV_TADS    4'hA

`endif

// ---- design/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_HOLDOFF
  } conv_state_t;

  typedef struct packed {
    conv_state_t state;
    logic        fmt;
    logic        refsel;
    logic [1:0]  chs;
    logic        go;
    logic        power;
    logic [9:0]  code;
    logic [3:0]  step;
    logic [9:0]  result;
    logic [1:0]  hold_cnt;
    logic [31:0] prdata;
    logic        slverr;
    logic        done;
    logic        cmp_s1;
    logic        cmp_s2;
  } adc_state_t;

endpackage

// ---- design/tad_timer.sv ----
`include "adc_ctrl_cfg.svh"

module tad_timer #(
  parameter int TAD_CYCLES = `TAD_CYC
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic restart,
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;
  } timer_state_t;

  localparam logic [15:0] RELOAD = 16'(TAD_CYCLES - 1);

  timer_state_t st_reg;
  timer_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (restart || st_reg.cnt == 16'h0000) begin
      st_next.cnt = RELOAD;
    end else begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = !restart && st_reg.cnt == 16'h0000;

endmodule // tad_timer

// ---- design/result_format.sv ----
module result_format (
  input  wire logic       right_just,
  input  wire logic [9:0] result,
  output logic      [7:0] res_high,
  output logic      [7:0] res_low
);

  always_comb begin
    if (right_just) begin
      res_high = {6'h00, result[9:8]};
      res_low  = result[7:0];
    end else begin
      res_high = result[9:2];
      res_low  = {result[1:0], 6'h00};
    end
  end

endmodule // result_format

// ---- verification/testbench.sv ----
`include "adc_ctrl_cfg.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TAD = 8;

  logic        ref_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        cmp_above;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [9:0]  dac_code;
  logic [3:0]  analog_select;
  logic        sample_enable;
  logic        reference_select;
  logic        converter_power_on;
  logic        conversion_done_flag;
  logic [9:0]  target;
  logic [31:0] rd;
  logic        err;
  logic        done_seen;
  int          n_errors;
  int          n_checks;
  int          cyc;

  adc_control_register #(.TAD_CYCLES(TAD)) adc_control_register_i (
    .ref_clk              (ref_clk),
    .nrst                 (nrst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pready               (pready),
    .prdata               (prdata),
    .pslverr              (pslverr),
    .cmp_above            (cmp_above),
    .dac_code             (dac_code),
    .analog_select        (analog_select),
    .sample_enable        (sample_enable),
    .reference_select     (reference_select),
    .converter_power_on   (converter_power_on),
    .conversion_done_flag (conversion_done_flag)
  );

  // ****************************************
  // Clock and analog input model
  // ****************************************
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cmp_above <= (target >= dac_code);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    n_errors++;
    $display("CHECK FAILED %s expected answer seen timeout", name);
    test_done();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done();
    for (cyc = 0; cyc < 2000; cyc++) begin
      @(posedge ref_clk);
      if (conversion_done_flag === 1'b1) break;
    end
    if (cyc == 2000) timeout("done");
  endtask

  task automatic read_result(input logic [7:0] hi, input logic [7:0] lo);
    apb(1'b0, `RES_HIGH_ADDR, 32'h0000_0000);
    check("result_high", rd, {24'h000000, hi});
    apb(1'b0, `RES_LOW_ADDR, 32'h0000_0000);
    check("result_low", rd, {24'h000000, lo});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmp_above = 1'b0;
    target = 10'h2A5;
    n_errors = 0;
    n_checks = 0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    check("power", converter_power_on, 1'b0);
    check("chan", analog_select, 4'h1);
    apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0000);
    $display("test reset done");

    for (int ch = 0; ch < 4; ch++) begin
      apb(1'b1, `CTRL_ADDR, 32'h0000_0031 | (ch << 2) | ((ch & 1) << 6));
      apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
      check("ctrl rdbk", rd, 32'h0000_0001 | (ch << 2) | ((ch & 1) << 6));
      check("chan", analog_select, 4'h1 << ch);
      check("refsel", reference_select, ch & 1);
      check("power", converter_power_on, 1'b1);
    end
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    $display("test fields done");

    apb(1'b1, `CTRL_ADDR, 32'h0000_0081);
    check("sampling", sample_enable, 1'b1);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0083);
    wait_done();
    check("dac code", dac_code, 10'h2A5);
    apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
    check("go cleared", rd, 32'h0000_0081);
    read_result(8'h02, 8'hA5);
    apb(1'b1, `RES_LOW_ADDR, 32'h0000_00FF);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0001);
    read_result(8'hA9, 8'h40);
    $display("test conversion done");

    target <= 10'h15A;
    apb(1'b1, `CTRL_ADDR, 32'h0000_0083);
    repeat (30) @(posedge ref_clk);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0081);
    done_seen = 1'b0;
    for (cyc = 0; cyc < 200; cyc++) begin
      @(posedge ref_clk);
      if (conversion_done_flag === 1'b1) done_seen = 1'b1;
      if (sample_enable === 1'b1) break;
    end
    check("abort no done", done_seen, 1'b0);
    check("holdoff", (cyc >= 2 * TAD - 1) && (cyc <= 2 * TAD + 4), 1'b1);
    read_result(8'h02, 8'hA5);
    $display("test abort done");

    apb(1'b1, `CTRL_ADDR, 32'h0000_0083);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0080);
    apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
    check("ctrl off", rd, 32'h0000_0080);
    check("power", converter_power_on, 1'b0);
    check("sampling", sample_enable, 1'b0);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0002);
    apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
    check("go while off", rd, 32'h0000_0000);
    $display("test power done");
    test_done();
  end

endmodule // testbench
